// *** verilog/lvmc_map.svh ***
// Purpose: Offsets, field positions, reset values and sizes of the supply monitor bank.
// Assumes: Register indices are word indices; the APB byte address is four times the index.
// Notes: Definitions only, no logic.
`ifndef LVMC_MAP_SVH
`define LVMC_MAP_SVH

`define LVMC_IDX_CTRL_A 16'h3040
`define LVMC_IDX_CTRL_B 16'h3041
`define LVMC_IDX_EVT_STATUS 16'h3042
`define LVMC_IDX_EVT_MASK 16'h3043
`define LVMC_IDX_LEVELS 16'h3044
`define LVMC_ADDR_SCALE 4

`define LVMC_RST_CTRL_A 8'h1c
`define LVMC_RST_CTRL_B 8'h00
`define LVMC_RST_EVT 2'h0

`define LVMC_A_WARN_FLAG 7
`define LVMC_A_WARN_ACK 6
`define LVMC_A_WARN_IRQ_EN 5
`define LVMC_A_RESET_EN 4
`define LVMC_A_STOP_EN 3
`define LVMC_A_DETECT_EN 2
`define LVMC_A_BUF_DRIVE 1
`define LVMC_A_BUF_EN 0

`define LVMC_B_DETECT_TRIP 6
`define LVMC_B_WARN_TRIP_HI 5
`define LVMC_B_WARN_TRIP_LO 4

`define LVMC_EVT_WARN 0
`define LVMC_EVT_DETECT 1
`define LVMC_EVT_BITS 2

`define LVMC_LVL_WARN 0
`define LVMC_LVL_DETECT 1
`define LVMC_LVL_ACTIVE 2

`endif

// *** verilog/lvmc_pkg.sv ***
// Purpose: Types shared by the supply monitor bank.
// Assumes: Constants live in lvmc_map.svh.
// Notes: The register select is one-hot so that decode faults show as several bits.
package lvmc_pkg;
   typedef logic [7:0] lvmc_byte_t;
   typedef logic [31:0] lvmc_word_t;
   typedef enum logic [5:0]
   {
      LVMC_SEL_NONE = 6'h01,
      LVMC_SEL_CTRL_A = 6'h02,
      LVMC_SEL_CTRL_B = 6'h04,
      LVMC_SEL_EVT_STATUS = 6'h08,
      LVMC_SEL_EVT_MASK = 6'h10,
      LVMC_SEL_LEVELS = 6'h20
   } lvmc_sel_e;
endpackage : lvmc_pkg

// *** verilog/lvmc_sync.sv ***
// Purpose: Two-stage synchroniser for asynchronous comparator levels.
// Assumes: Inputs are slow levels; no pulse shorter than two clocks must be seen.
// Notes: Only the second stage is visible outside.
`timescale 1ns/100ps
module lvmc_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   generate
      if (WIDTH < 1)
      begin : g_bad_width
         $error("lvmc_sync needs at least one bit");
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : lvmc_sync

// *** verilog/lvmc_top.sv ***
// Purpose: Control and status bank of the supply low-voltage monitor, reached over APB.
// Assumes: Comparator inputs are asynchronous levels, high while the supply is below the trip.
// Notes: Zero wait state slave; read data is captured in the setup cycle.
// Notes on behaviour
// - Control A at index 3040h, resets 1Ch.
// - Control B at index 3041h, resets 00h.
// - Warning flag sets on low supply while detection is active, even after reset.
// - Warning flag sticky until acknowledged.
// - Ack bit 6 clears flag once warning gone.
// - Bit 5 with flag raises interrupt.
// - Bit 4 forces reset on enabled detect.
// - Write-once bits accept first write only.
// - Bit 3 keeps detection alive in stop.
// - Bit 2 enables detection, gates bits 3-4.
// - Control B bit 6 write-once detect trip.
// - Control B bits 5-4 pick warning trip.
// - Bit 0 buffer enable, bit 1 drive.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`include "lvmc_map.svh"
module lvmc_top #(
   parameter int ADDR_WIDTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire lvmc_pkg::lvmc_word_t pwdata,
   input wire logic [3:0] pstrb,
   output lvmc_pkg::lvmc_word_t prdata,
   output logic pready,
   output logic pslverr,
   input wire logic detect_cmp_raw,
   input wire logic warning_cmp_raw,
   input wire logic stop_mode,
   output logic detect_active,
   output logic detect_trip_select,
   output logic [1:0] warning_trip_select,
   output logic ref_buffer_enable,
   output logic ref_buffer_drive_select,
   output logic system_reset_req,
   output logic irq
);
   import lvmc_pkg::*;

   localparam logic [ADDR_WIDTH-1:0] ADDR_CTRL_A =
      ADDR_WIDTH'(`LVMC_IDX_CTRL_A * `LVMC_ADDR_SCALE);
   localparam logic [ADDR_WIDTH-1:0] ADDR_CTRL_B =
      ADDR_WIDTH'(`LVMC_IDX_CTRL_B * `LVMC_ADDR_SCALE);
   localparam logic [ADDR_WIDTH-1:0] ADDR_EVT_STATUS =
      ADDR_WIDTH'(`LVMC_IDX_EVT_STATUS * `LVMC_ADDR_SCALE);
   localparam logic [ADDR_WIDTH-1:0] ADDR_EVT_MASK =
      ADDR_WIDTH'(`LVMC_IDX_EVT_MASK * `LVMC_ADDR_SCALE);
   localparam logic [ADDR_WIDTH-1:0] ADDR_LEVELS =
      ADDR_WIDTH'(`LVMC_IDX_LEVELS * `LVMC_ADDR_SCALE);
   localparam lvmc_byte_t RST_A = `LVMC_RST_CTRL_A;
   localparam lvmc_byte_t RST_B = `LVMC_RST_CTRL_B;

   // The highest byte address must fit the address bus.
   generate
      if (ADDR_WIDTH < 16 || ADDR_WIDTH > 32)
      begin : g_bad_addr
         $error("lvmc_top needs ADDR_WIDTH between 16 and 32");
      end
   endgenerate

   logic [1:0] cmp_sync;
   logic warn_s;
   logic detect_s;
   lvmc_sel_e sel;
   logic setup_phase;
   logic write_take;
   logic wr_a;
   logic wr_b;
   logic wr_status;
   logic wr_mask;
   lvmc_word_t rdata_mux;

   logic warn_flag_q;
   logic warn_irq_en_q;
   logic reset_en_q;
   logic stop_en_q;
   logic detect_en_q;
   logic buf_drive_q;
   logic buf_en_q;
   logic detect_trip_q;
   logic [1:0] warn_trip_q;
   logic once_a_used_q;
   logic once_b_used_q;
   logic warn_flag_seen_q;
   logic detect_hit_q;
   logic [`LVMC_EVT_BITS-1:0] evt_status_q;
   logic [`LVMC_EVT_BITS-1:0] evt_mask_q;
   logic [`LVMC_EVT_BITS-1:0] evt_set;
   logic detect_hit;

   lvmc_sync #(
      .WIDTH(2)
   ) u_cmp_sync (
      .clk(pclk),
      .rst_n(presetn),
      .async_in({detect_cmp_raw, warning_cmp_raw}),
      .sync_out(cmp_sync)
   );

   // Nothing reads the raw comparators past this point.
   assign warn_s = cmp_sync[0];
   assign detect_s = cmp_sync[1];

   always_comb
   begin
      sel = LVMC_SEL_NONE;
      if (paddr == ADDR_CTRL_A)
      begin
         sel = LVMC_SEL_CTRL_A;
      end
      else if (paddr == ADDR_CTRL_B)
      begin
         sel = LVMC_SEL_CTRL_B;
      end
      else if (paddr == ADDR_EVT_STATUS)
      begin
         sel = LVMC_SEL_EVT_STATUS;
      end
      else if (paddr == ADDR_EVT_MASK)
      begin
         sel = LVMC_SEL_EVT_MASK;
      end
      else if (paddr == ADDR_LEVELS)
      begin
         sel = LVMC_SEL_LEVELS;
      end
   end

   assign setup_phase = psel && !penable;
   assign write_take = psel && penable && pwrite && pstrb[0];
   assign wr_a = write_take && (sel == LVMC_SEL_CTRL_A);
   assign wr_b = write_take && (sel == LVMC_SEL_CTRL_B);
   assign wr_status = write_take && (sel == LVMC_SEL_EVT_STATUS);
   assign wr_mask = write_take && (sel == LVMC_SEL_EVT_MASK);

   assign pready = 1'b1;
   assign pslverr = psel && penable && (sel == LVMC_SEL_NONE);

   always_comb
   begin
      rdata_mux = '0;
      case (sel)
         LVMC_SEL_CTRL_A:
         begin
            // The acknowledge bit is a write-only strobe and reads as zero.
            rdata_mux[`LVMC_A_WARN_FLAG] = warn_flag_q;
            rdata_mux[`LVMC_A_WARN_IRQ_EN] = warn_irq_en_q;
            rdata_mux[`LVMC_A_RESET_EN] = reset_en_q;
            rdata_mux[`LVMC_A_STOP_EN] = stop_en_q;
            rdata_mux[`LVMC_A_DETECT_EN] = detect_en_q;
            rdata_mux[`LVMC_A_BUF_DRIVE] = buf_drive_q;
            rdata_mux[`LVMC_A_BUF_EN] = buf_en_q;
         end
         LVMC_SEL_CTRL_B:
         begin
            rdata_mux[`LVMC_B_DETECT_TRIP] = detect_trip_q;
            rdata_mux[`LVMC_B_WARN_TRIP_HI:`LVMC_B_WARN_TRIP_LO] = warn_trip_q;
         end
         LVMC_SEL_EVT_STATUS:
         begin
            rdata_mux[`LVMC_EVT_BITS-1:0] = evt_status_q;
         end
         LVMC_SEL_EVT_MASK:
         begin
            rdata_mux[`LVMC_EVT_BITS-1:0] = evt_mask_q;
         end
         LVMC_SEL_LEVELS:
         begin
            rdata_mux[`LVMC_LVL_WARN] = warn_s;
            rdata_mux[`LVMC_LVL_DETECT] = detect_s;
            rdata_mux[`LVMC_LVL_ACTIVE] = detect_active;
         end
         LVMC_SEL_NONE:
         begin
            rdata_mux = '0;
         end
         default:
         begin
            rdata_mux = '0;
         end
      endcase
   end

   // Captured in setup so the access cycle presents a registered word.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= '0;
      end
      else if (setup_phase && !pwrite)
      begin
         prdata <= rdata_mux;
      end
   end

   // Bits free to change on every write.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         warn_irq_en_q <= RST_A[`LVMC_A_WARN_IRQ_EN];
         stop_en_q <= RST_A[`LVMC_A_STOP_EN];
         buf_drive_q <= RST_A[`LVMC_A_BUF_DRIVE];
         buf_en_q <= RST_A[`LVMC_A_BUF_EN];
         warn_trip_q <= RST_B[`LVMC_B_WARN_TRIP_HI:`LVMC_B_WARN_TRIP_LO];
      end
      else
      begin
         if (wr_a)
         begin
            warn_irq_en_q <= pwdata[`LVMC_A_WARN_IRQ_EN];
            stop_en_q <= pwdata[`LVMC_A_STOP_EN];
            buf_drive_q <= pwdata[`LVMC_A_BUF_DRIVE];
            buf_en_q <= pwdata[`LVMC_A_BUF_EN];
         end
         if (wr_b)
         begin
            warn_trip_q <= pwdata[`LVMC_B_WARN_TRIP_HI:`LVMC_B_WARN_TRIP_LO];
         end
      end
   end

   // Write-once bits: a write that finds the register already used changes nothing.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reset_en_q <= RST_A[`LVMC_A_RESET_EN];
         detect_en_q <= RST_A[`LVMC_A_DETECT_EN];
         detect_trip_q <= RST_B[`LVMC_B_DETECT_TRIP];
         once_a_used_q <= 1'b0;
         once_b_used_q <= 1'b0;
      end
      else
      begin
         if (wr_a && !once_a_used_q)
         begin
            reset_en_q <= pwdata[`LVMC_A_RESET_EN];
            detect_en_q <= pwdata[`LVMC_A_DETECT_EN];
            once_a_used_q <= 1'b1;
         end
         if (wr_b && !once_b_used_q)
         begin
            detect_trip_q <= pwdata[`LVMC_B_DETECT_TRIP];
            once_b_used_q <= 1'b1;
         end
      end
   end

   // Stop mode only silences the monitor when the stop enable is clear.
   assign detect_active = detect_en_q && (!stop_mode || stop_en_q);

   // The flag is forced while the warning stands and detection is active, so an
   // acknowledge that then meets a still-low supply loses and the flag stays set.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         warn_flag_q <= 1'b0;
      end
      else if (detect_active && warn_s)
      begin
         warn_flag_q <= 1'b1;
      end
      else if (wr_a && pwdata[`LVMC_A_WARN_ACK])
      begin
         warn_flag_q <= 1'b0;
      end
   end

   assign detect_hit = detect_active && detect_s;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         warn_flag_seen_q <= 1'b0;
         detect_hit_q <= 1'b0;
      end
      else
      begin
         warn_flag_seen_q <= warn_flag_q;
         detect_hit_q <= detect_hit;
      end
   end

   // Held while the condition stands; the reset controller stretches it as it needs.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         system_reset_req <= 1'b0;
      end
      else
      begin
         system_reset_req <= detect_hit && reset_en_q;
      end
   end

   assign evt_set[`LVMC_EVT_WARN] = warn_flag_q && !warn_flag_seen_q;
   assign evt_set[`LVMC_EVT_DETECT] = detect_hit && !detect_hit_q;

   // A new event in the cycle of its clear still leaves the bit set.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         evt_status_q <= `LVMC_RST_EVT;
      end
      else if (wr_status)
      begin
         evt_status_q <= (evt_status_q & ~pwdata[`LVMC_EVT_BITS-1:0]) | evt_set;
      end
      else
      begin
         evt_status_q <= evt_status_q | evt_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         evt_mask_q <= `LVMC_RST_EVT;
      end
      else if (wr_mask)
      begin
         evt_mask_q <= pwdata[`LVMC_EVT_BITS-1:0];
      end
   end

   // The warning request follows the flag directly so that polling and interrupt agree.
   assign irq = (warn_irq_en_q && warn_flag_q) || (|(evt_status_q & evt_mask_q));

   assign detect_trip_select = detect_trip_q;
   assign warning_trip_select = warn_trip_q;
   assign ref_buffer_enable = buf_en_q;
   assign ref_buffer_drive_select = buf_drive_q;
endmodule : lvmc_top

// *** tb/lvmc_monitor.sv ***
// Purpose: Concurrent checks of the supply monitor bank at its ports.
// Assumes: Zero wait state APB; control fields are shadowed from bus writes.
// Notes: The warning flag is set from the analog input, so it is not shadowed.
`timescale 1ns/100ps
`include "lvmc_map.svh"
module lvmc_monitor #(
   parameter int ADDR_WIDTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire lvmc_pkg::lvmc_word_t pwdata,
   input wire logic [3:0] pstrb,
   input wire lvmc_pkg::lvmc_word_t prdata,
   input wire logic detect_cmp_raw,
   input wire logic stop_mode,
   input wire logic detect_active,
   input wire logic detect_trip_select,
   input wire logic [1:0] warning_trip_select,
   input wire logic ref_buffer_enable,
   input wire logic ref_buffer_drive_select,
   input wire logic system_reset_req,
   input wire logic irq
);
   import lvmc_pkg::*;
   localparam int AA = `LVMC_IDX_CTRL_A * `LVMC_ADDR_SCALE;
   logic [7:0] sa_q;
   logic [7:0] sb_q;
   logic [1:0] m_q;
   logic oa_q;
   logic ob_q;
   logic wr;
   logic rd;
   assign wr = psel && penable && pwrite && pstrb[0];
   assign rd = psel && penable && !pwrite;
   // Write-once fields keep their value after the first write of their register.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sa_q <= `LVMC_RST_CTRL_A;
         sb_q <= `LVMC_RST_CTRL_B;
         m_q <= 2'h0;
         oa_q <= 1'b0;
         ob_q <= 1'b0;
      end
      else if (wr && paddr == ADDR_WIDTH'(AA))
      begin
         sa_q <= {2'h0, pwdata[5], oa_q ? sa_q[4] : pwdata[4], pwdata[3],
            oa_q ? sa_q[2] : pwdata[2], pwdata[1:0]};
         oa_q <= 1'b1;
      end
      else if (wr && paddr == ADDR_WIDTH'(AA + 4))
      begin
         sb_q <= {1'b0, ob_q ? sb_q[6] : pwdata[6], pwdata[5:4], 4'h0};
         ob_q <= 1'b1;
      end
      else if (wr && paddr == ADDR_WIDTH'(AA + 12))
         m_q <= pwdata[1:0];
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_buf;
      ref_buffer_enable == sa_q[0] && ref_buffer_drive_select == sa_q[1];
   endproperty
   a_buf: assert property (p_buf) else $error("buffer controls wrong");
   property p_dact;
      detect_active == (sa_q[2] && (!stop_mode || sa_q[3]));
   endproperty
   a_dact: assert property (p_dact) else $error("detect active wrong");
   property p_rda;
      rd && paddr == ADDR_WIDTH'(AA) |-> prdata[31:8] == 24'h0 && prdata[6:0] == {1'b0, sa_q[5:0]};
   endproperty
   a_rda: assert property (p_rda) else $error("control A read wrong");
   property p_rdb;
      rd && paddr == ADDR_WIDTH'(AA + 4) |-> prdata == {24'h0, sb_q};
   endproperty
   a_rdb: assert property (p_rdb) else $error("control B read wrong");
   property p_dtrip;
      detect_trip_select == sb_q[6];
   endproperty
   a_dtrip: assert property (p_dtrip) else $error("detect trip wrong");
   property p_wtrip;
      warning_trip_select == sb_q[5:4];
   endproperty
   a_wtrip: assert property (p_wtrip) else $error("warning trip wrong");
   property p_irq;
      !sa_q[5] && m_q == 2'h0 |-> !irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt while disabled");
   property p_rgate;
      system_reset_req |-> $past(detect_active) && $past(sa_q[4]);
   endproperty
   a_rgate: assert property (p_rgate) else $error("reset request not enabled");
   property p_rsync;
      $rose(system_reset_req) |-> $past(detect_cmp_raw, 2) && $past(detect_cmp_raw, 3);
   endproperty
   a_rsync: assert property (p_rsync) else $error("reset request too early");
endmodule : lvmc_monitor
bind lvmc_top lvmc_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) lvmc_monitor_i (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pstrb(pstrb),
   .prdata(prdata),
   .detect_cmp_raw(detect_cmp_raw),
   .stop_mode(stop_mode),
   .detect_active(detect_active),
   .detect_trip_select(detect_trip_select),
   .warning_trip_select(warning_trip_select),
   .ref_buffer_enable(ref_buffer_enable),
   .ref_buffer_drive_select(ref_buffer_drive_select),
   .system_reset_req(system_reset_req),
   .irq(irq)
);

// *** tb/lvmc_top_tb.sv ***
// Purpose: Self-checking bench of the supply monitor bank.
// Assumes: Zero wait state APB slave; comparators driven as slow levels.
// Notes: A second reset is needed because the write-once bits are spent early.
`timescale 1ns/100ps
`include "lvmc_map.svh"
module lvmc_top_tb;
   import lvmc_pkg::*;
   localparam logic [15:0] AA = 16'(`LVMC_IDX_CTRL_A * `LVMC_ADDR_SCALE);
   localparam logic [15:0] AB = AA + 16'h4;
   localparam logic [15:0] AS = AA + 16'h8;
   localparam logic [15:0] AM = AA + 16'hc;
   logic pclk, presetn, psel, penable, pwrite, dcr, wcr, stp, er;
   logic pready, pslverr, dact, dts, rbe, rbd, srr, irq;
   logic [15:0] paddr;
   logic [3:0] pstrb;
   logic [1:0] wts;
   lvmc_word_t pwdata, prdata, rd;
   int n_fail, cmp_count;
   lvmc_top lvmc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .detect_cmp_raw(dcr), .warning_cmp_raw(wcr),
      .stop_mode(stp), .detect_active(dact), .detect_trip_select(dts),
      .warning_trip_select(wts), .ref_buffer_enable(rbe), .ref_buffer_drive_select(rbd),
      .system_reset_req(srr), .irq(irq));
   task automatic chk(input lvmc_word_t seen, input lvmc_word_t exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude();
      if (n_fail == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude
   task automatic xfer(input logic w, input logic [15:0] a, input lvmc_word_t d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the watchdog ends a wait for an answer that never comes.
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [15:0] a, input lvmc_word_t d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rc(input logic [15:0] a, input lvmc_word_t exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rc
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : settle
   task automatic t_once();
      rc(AA, 32'h1c);
      rc(AB, 32'h0);
      xfer(1'b0, AA + 16'h20, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      wr(AA, 32'h03);
      rc(AA, 32'h03);
      chk(32'({rbd, rbe}), 32'h3);
      wr(AA, 32'h1c);
      rc(AA, 32'h08);
      settle(0);
      chk(32'(dact), 32'h0);
   endtask : t_once
   task automatic t_warn();
      @(posedge pclk);
      wcr <= 1'b1;
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      settle(4);
      rc(AA, 32'h9c);
      wr(AA, 32'h1c);
      wr(AA, 32'h5c);
      rc(AA, 32'h9c);
      @(posedge pclk);
      wcr <= 1'b0;
      settle(4);
      rc(AA, 32'h9c);
      chk(32'(irq), 32'h0);
      wr(AA, 32'h5c);
      rc(AA, 32'h1c);
      wr(AA, 32'h3c);
      settle(0);
      chk(32'(irq), 32'h0);
      @(posedge pclk);
      wcr <= 1'b1;
      settle(4);
      chk(32'(irq), 32'h1);
      @(posedge pclk);
      wcr <= 1'b0;
      wr(AA, 32'h1c);
      settle(0);
      chk(32'(irq), 32'h0);
      rc(AS, 32'h1);
      wr(AM, 32'h1);
      settle(0);
      chk(32'(irq), 32'h1);
      wr(AS, 32'h1);
      rc(AS, 32'h0);
      chk(32'(irq), 32'h0);
      wr(AM, 32'h0);
      wr(AA, 32'h5c);
   endtask : t_warn
   task automatic t_detect();
      @(posedge pclk);
      dcr <= 1'b1;
      settle(2);
      chk(32'(srr), 32'h0);
      settle(1);
      chk(32'(srr), 32'h1);
      @(posedge pclk);
      stp <= 1'b1;
      settle(3);
      chk({31'h0, dact & srr}, 32'h1);
      rc(AA + 16'h10, 32'h6);
      wr(AA, 32'h14);
      settle(0);
      chk(32'(dact), 32'h0);
      settle(2);
      chk(32'(srr), 32'h0);
      @(posedge pclk);
      dcr <= 1'b0;
      settle(4);
      @(posedge pclk);
      stp <= 1'b0;
   endtask : t_detect
   task automatic t_trip();
      wr(AB, 32'hff);
      rc(AB, 32'h70);
      wr(AB, 32'h00);
      rc(AB, 32'h40);
      chk(32'(dts), 32'h1);
      for (int i = 0; i < 4; i++)
      begin
         wr(AB, 32'(i << 4));
         settle(0);
         chk(32'(wts), 32'(i));
      end
      // A write without its byte strobe must leave the register alone.
      @(posedge pclk);
      pstrb <= 4'h0;
      wr(AB, 32'h00);
      pstrb <= 4'h1;
      rc(AB, 32'h70);
   endtask : t_trip
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial
   begin
      #500000;
      n_fail++;
      conclude();
   end
   initial
   begin
      {presetn, psel, penable, pwrite, dcr, wcr, stp} = 7'h0;
      paddr = 16'h0;
      pwdata = 32'h0;
      pstrb = 4'h1;
      n_fail = 0;
      cmp_count = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_once();
      t_warn();
      t_detect();
      t_trip();
      conclude();
   end
endmodule : lvmc_top_tb
